// File: verilog/bstp_pkg.sv
package bstp_pkg;
   // register lengths
   localparam int IR_LEN = 10;
   localparam int BYP_LEN = 1;
   localparam int ID_LEN = 32;
   localparam int SIG_LEN = 16;
   // boundary length steps
   localparam int BSR_MIN = 504;
   localparam int BSR_MAX = 648;
   localparam int BSR_STEP = 48;
   // identification field positions
   localparam int ID_VER_LSB = 28;
   localparam int ID_PART_LSB = 12;
   localparam int ID_MFR_LSB = 1;
   localparam logic ID_FIXED_BIT = 1'b1;
   // opcodes are not given; neutral choices
   localparam logic [9:0] OP_EXTEST = 10'h000;
   localparam logic [9:0] OP_SAMPLE = 10'h055;
   localparam logic [9:0] OP_IDCODE = 10'h059;
   localparam logic [9:0] OP_USERSIG = 10'h079;
   localparam logic [9:0] OP_PROG_ENTER = 10'h0A0;
   localparam logic [9:0] OP_PROG_EXIT = 10'h0A1;
   localparam logic [9:0] OP_PROG_ADDR = 10'h0A2;
   localparam logic [9:0] OP_PROG_DATA = 10'h0A3;
   localparam logic [9:0] OP_BYPASS = 10'h3FF;
   localparam logic [1:0] IR_CAPTURE = 2'h1;
   localparam logic [15:0] PROG_REG_RESET = 16'h0000;

   typedef enum logic [2:0] {
      BSTP_SEL_BYPASS,
      BSTP_SEL_BOUNDARY,
      BSTP_SEL_ID,
      BSTP_SEL_SIG,
      BSTP_SEL_PROG
   } bstp_sel_t;

   typedef struct packed {
      logic capture;
      logic shift;
      logic update;
      logic reset;
   } bstp_ctl_t;
endpackage : bstp_pkg

// File: verilog/bstp_tap_fsm.sv
`timescale 1ns/100ps
`default_nettype none
module bstp_tap_fsm (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic tck_rise,
   input wire logic tms,
   output bstp_pkg::bstp_ctl_t dr_ctl,
   output bstp_pkg::bstp_ctl_t ir_ctl,
   output logic shifting
);
   typedef enum logic [3:0] {
      RESET, IDLE, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UP_DR,
      SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UP_IR
   } bstp_tap_t;
   bstp_tap_t state_q;
   bstp_tap_t state_d;

   // standard sixteen-state controller
   always_comb begin
      unique case (state_q)
         RESET: state_d = tms ? RESET : IDLE;
         IDLE: state_d = tms ? SEL_DR : IDLE;
         SEL_DR: state_d = tms ? SEL_IR : CAP_DR;
         CAP_DR: state_d = tms ? EX1_DR : SH_DR;
         SH_DR: state_d = tms ? EX1_DR : SH_DR;
         EX1_DR: state_d = tms ? UP_DR : PA_DR;
         PA_DR: state_d = tms ? EX2_DR : PA_DR;
         EX2_DR: state_d = tms ? UP_DR : SH_DR;
         UP_DR: state_d = tms ? SEL_DR : IDLE;
         SEL_IR: state_d = tms ? RESET : CAP_IR;
         CAP_IR: state_d = tms ? EX1_IR : SH_IR;
         SH_IR: state_d = tms ? EX1_IR : SH_IR;
         EX1_IR: state_d = tms ? UP_IR : PA_IR;
         PA_IR: state_d = tms ? EX2_IR : PA_IR;
         EX2_IR: state_d = tms ? UP_IR : SH_IR;
         UP_IR: state_d = tms ? SEL_DR : IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= RESET;
      end else if (tck_rise) begin
         state_q <= state_d;
      end
   end

   // capture, shift and update fire on the tck rise that leaves the state; reset is held for the whole RESET state
   assign dr_ctl.capture = tck_rise && state_q == CAP_DR;
   assign dr_ctl.shift = tck_rise && state_q == SH_DR;
   assign dr_ctl.update = tck_rise && state_q == UP_DR;
   assign dr_ctl.reset = state_q == RESET;
   assign ir_ctl.capture = tck_rise && state_q == CAP_IR;
   assign ir_ctl.shift = tck_rise && state_q == SH_IR;
   assign ir_ctl.update = tck_rise && state_q == UP_IR;
   assign ir_ctl.reset = state_q == RESET;
   assign shifting = state_q == SH_DR || state_q == SH_IR;
endmodule : bstp_tap_fsm
`default_nettype wire

// File: verilog/bstp_shreg.sv
`timescale 1ns/100ps
`default_nettype none
module bstp_shreg #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic capture,
   input wire logic shift,
   input wire logic [W-1:0] cap_val,
   input wire logic sin,
   output logic [W-1:0] q
);
   // lsb goes out first, new bits enter at the msb
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         q <= '0;
      end else if (capture) begin
         q <= cap_val;
      end else if (shift) begin
         q <= {sin, q[W-1:1]};
      end
   end
endmodule : bstp_shreg
`default_nettype wire

// File: verilog/bstp_boundary_scan_circuitry.sv
`timescale 1ns/100ps
`default_nettype none
module bstp_boundary_scan_circuitry #(
   parameter int BSR_LEN = bstp_pkg::BSR_MIN,
   parameter int NUM_PINS = BSR_LEN / 3,
   parameter bit HAS_ID = 1'b1,
   parameter bit HAS_SIG = 1'b1,
   parameter logic [3:0] ID_VERSION = 4'h1,
   parameter logic [15:0] ID_PART = 16'h1234,
   parameter logic [10:0] ID_MAKER = 11'h2AA,
   parameter logic [15:0] USER_SIG = 16'hA5C3
) (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic PORT_ENABLE,
   input wire logic TCK_IN,
   input wire logic TMS_IN,
   input wire logic TDI_IN,
   output logic TDO_OUT,
   output logic TDO_OE,
   output logic [3:0] USER_PIN_IN,
   input wire logic [3:0] USER_PIN_OUT,
   input wire logic [3:0] USER_PIN_OE,
   output logic [3:0] PORTPIN_OUT,
   output logic [3:0] PORTPIN_OE,
   input wire logic [NUM_PINS-1:0] CORE_OUT,
   input wire logic [NUM_PINS-1:0] CORE_OE,
   input wire logic [NUM_PINS-1:0] PAD_IN,
   output logic [NUM_PINS-1:0] PAD_OUT,
   output logic [NUM_PINS-1:0] PAD_OE,
   output logic [NUM_PINS-1:0] CORE_IN,
   output logic PROG_ACTIVE,
   output logic [9:0] PROG_INSTR,
   output logic [15:0] PROG_DATA,
   output logic PROG_DATA_STB
);
   localparam int ID_W = bstp_pkg::ID_LEN;
   localparam int SIG_W = bstp_pkg::SIG_LEN;
   localparam int IR_W = bstp_pkg::IR_LEN;

   // cells are per pin: input, output, enable; length must be a legal variant
   initial begin
      if (BSR_LEN < bstp_pkg::BSR_MIN || BSR_LEN > bstp_pkg::BSR_MAX ||
          (BSR_LEN - bstp_pkg::BSR_MIN) % bstp_pkg::BSR_STEP != 0 || BSR_LEN != 3 * NUM_PINS) begin
         $error("illegal boundary length");
      end
   end

   // the test-port pins are asynchronous to CLOCK; two stages each
   logic [3:0] port_s1_q;
   logic [3:0] port_s2_q;
   logic tck_prev_q;
   logic en_s1_q;
   logic en_s2_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         port_s1_q <= 4'h0;
         port_s2_q <= 4'h0;
         tck_prev_q <= 1'b0;
         en_s1_q <= 1'b0;
         en_s2_q <= 1'b0;
      end else begin
         port_s1_q <= {TDI_IN, TMS_IN, TCK_IN, 1'b0};
         port_s2_q <= port_s1_q;
         tck_prev_q <= port_s2_q[1];
         en_s1_q <= PORT_ENABLE;
         en_s2_q <= en_s1_q;
      end
   end
   wire tck_s = port_s2_q[1];
   wire tms_s = port_s2_q[2];
   wire tdi_s = port_s2_q[3];
   // while disabled tck edges are ignored and tms reads high; after enable tms passes straight through, so the host walks to test reset
   wire tck_rise = en_s2_q && tck_s && !tck_prev_q;
   wire tck_fall = en_s2_q && !tck_s && tck_prev_q;
   wire tms_eff = tms_s || !en_s2_q;

   bstp_pkg::bstp_ctl_t dr;
   bstp_pkg::bstp_ctl_t ir;
   logic shifting;
   bstp_tap_fsm u_tap (
      .clk(CLOCK),
      .arst_n(ARST_N),
      .tck_rise(tck_rise),
      .tms(tms_eff),
      .dr_ctl(dr),
      .ir_ctl(ir),
      .shifting(shifting)
   );

   // instruction register
   localparam logic [9:0] RESET_OP = HAS_ID ? bstp_pkg::OP_IDCODE : bstp_pkg::OP_BYPASS;
   logic [IR_W-1:0] ir_shift_q;
   logic [IR_W-1:0] ir_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         ir_shift_q <= '0;
         ir_q <= RESET_OP;
      end else if (ir.reset) begin
         ir_q <= RESET_OP;
      end else begin
         if (ir.capture) ir_shift_q <= {{(IR_W - 2){1'b0}}, bstp_pkg::IR_CAPTURE};
         else if (ir.shift) ir_shift_q <= {tdi_s, ir_shift_q[IR_W-1:1]};
         if (ir.update) ir_q <= ir_shift_q;
      end
   end

   // decode; unknown or unsupported codes fall to bypass
   wire is_extest = ir_q == bstp_pkg::OP_EXTEST;
   wire is_sample = ir_q == bstp_pkg::OP_SAMPLE;
   wire is_id = HAS_ID && ir_q == bstp_pkg::OP_IDCODE;
   wire is_sig = HAS_SIG && ir_q == bstp_pkg::OP_USERSIG;
   wire is_prog_data = ir_q == bstp_pkg::OP_PROG_ADDR || ir_q == bstp_pkg::OP_PROG_DATA;
   wire is_prog = is_prog_data || ir_q == bstp_pkg::OP_PROG_ENTER || ir_q == bstp_pkg::OP_PROG_EXIT;
   bstp_pkg::bstp_sel_t sel;
   assign sel = is_extest || is_sample ? bstp_pkg::BSTP_SEL_BOUNDARY :
                is_id ? bstp_pkg::BSTP_SEL_ID :
                is_sig ? bstp_pkg::BSTP_SEL_SIG :
                is_prog_data ? bstp_pkg::BSTP_SEL_PROG :
                bstp_pkg::BSTP_SEL_BYPASS;

   // bypass: one stage, captures zero
   logic byp_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         byp_q <= 1'b0;
      end else if (sel == bstp_pkg::BSTP_SEL_BYPASS && dr.capture) begin
         byp_q <= 1'b0;
      end else if (sel == bstp_pkg::BSTP_SEL_BYPASS && dr.shift) begin
         byp_q <= tdi_s;
      end
   end

   // identification and signature
   wire [ID_W-1:0] id_val = {ID_VERSION, ID_PART, ID_MAKER, bstp_pkg::ID_FIXED_BIT};
   logic [ID_W-1:0] id_q;
   bstp_shreg #(.W(ID_W)) u_id (
      .clk(CLOCK),
      .arst_n(ARST_N),
      .capture(dr.capture && sel == bstp_pkg::BSTP_SEL_ID),
      .shift(dr.shift && sel == bstp_pkg::BSTP_SEL_ID),
      .cap_val(id_val),
      .sin(tdi_s),
      .q(id_q)
   );
   logic [SIG_W-1:0] sig_q;
   bstp_shreg #(.W(SIG_W)) u_sig (
      .clk(CLOCK),
      .arst_n(ARST_N),
      .capture(dr.capture && sel == bstp_pkg::BSTP_SEL_SIG),
      .shift(dr.shift && sel == bstp_pkg::BSTP_SEL_SIG),
      .cap_val(USER_SIG),
      .sin(tdi_s),
      .q(sig_q)
   );

   // programming data path; the engine itself lies outside
   logic [SIG_W-1:0] prog_q;
   bstp_shreg #(.W(SIG_W)) u_prog (
      .clk(CLOCK),
      .arst_n(ARST_N),
      .capture(dr.capture && sel == bstp_pkg::BSTP_SEL_PROG),
      .shift(dr.shift && sel == bstp_pkg::BSTP_SEL_PROG),
      .cap_val(PROG_DATA),
      .sin(tdi_s),
      .q(prog_q)
   );

   // boundary register: per pin {enable, output, input}, input cell nearest tdo
   wire [BSR_LEN-1:0] bsr_cap;
   logic [BSR_LEN-1:0] bsr_q;
   logic [BSR_LEN-1:0] bsr_upd_q;
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g = g + 1) begin : g_cell
         assign bsr_cap[3*g] = PAD_IN[g];
         assign bsr_cap[3*g+1] = CORE_OUT[g];
         assign bsr_cap[3*g+2] = CORE_OE[g];
      end
   endgenerate
   wire bsr_sel = sel == bstp_pkg::BSTP_SEL_BOUNDARY;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         bsr_q <= '0;
         bsr_upd_q <= '0;
      end else begin
         if (bsr_sel && dr.capture) bsr_q <= bsr_cap;
         else if (bsr_sel && dr.shift) bsr_q <= {tdi_s, bsr_q[BSR_LEN-1:1]};
         if (bsr_sel && dr.update) bsr_upd_q <= bsr_q;
      end
   end

   // pin muxing: extest drives held pattern, else the core passes through
   logic [NUM_PINS-1:0] pad_out_d;
   logic [NUM_PINS-1:0] pad_oe_d;
   logic [NUM_PINS-1:0] core_in_d;
   always_comb begin
      for (int i = 0; i < NUM_PINS; i++) begin
         pad_out_d[i] = is_extest ? bsr_upd_q[3*i+1] : CORE_OUT[i];
         pad_oe_d[i] = is_extest ? bsr_upd_q[3*i+2] : CORE_OE[i];
         // during extest the core sees the held pattern, keeping it isolated
         core_in_d[i] = is_extest ? bsr_upd_q[3*i] : PAD_IN[i];
      end
   end

   // serial output mux, changes on the falling edge of tck
   logic tdo_d;
   always_comb begin
      unique case (sel)
         bstp_pkg::BSTP_SEL_BOUNDARY: tdo_d = bsr_q[0];
         bstp_pkg::BSTP_SEL_ID: tdo_d = id_q[0];
         bstp_pkg::BSTP_SEL_SIG: tdo_d = sig_q[0];
         bstp_pkg::BSTP_SEL_PROG: tdo_d = prog_q[0];
         default: tdo_d = byp_q;
      endcase
   end
   // the first bit of a scan leaves on the fall right after capture, before any shift;
   // so the path is chosen by the column that captured last, not by the shift action
   logic ir_col_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         ir_col_q <= 1'b0;
      end else if (ir.capture) begin
         ir_col_q <= 1'b1;
      end else if (dr.capture) begin
         ir_col_q <= 1'b0;
      end
   end
   wire tdo_bit = ir_col_q ? ir_shift_q[0] : tdo_d;

   // serial output; enable follows the shift states and drops once the port is given away
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         TDO_OUT <= 1'b0;
         TDO_OE <= 1'b0;
      end else if (tck_fall) begin
         TDO_OUT <= tdo_bit;
         TDO_OE <= shifting;
      end else if (!en_s2_q) begin
         TDO_OE <= 1'b0;
      end
   end

   // pad and core path
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         PAD_OUT <= '0;
         PAD_OE <= '0;
         CORE_IN <= '0;
      end else begin
         PAD_OUT <= pad_out_d;
         PAD_OE <= pad_oe_d;
         CORE_IN <= core_in_d;
      end
   end

   // the four port pins as user pins; the port keeps priority while enabled
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         USER_PIN_IN <= 4'h0;
         PORTPIN_OUT <= 4'h0;
         PORTPIN_OE <= 4'h0;
      end else begin
         USER_PIN_IN <= en_s2_q ? 4'h0 : port_s2_q;
         PORTPIN_OUT <= USER_PIN_OUT;
         PORTPIN_OE <= en_s2_q ? 4'h0 : USER_PIN_OE;
      end
   end

   // hand-off to the programming engine; strobe and word land on the same edge
   logic prog_active_q;
   logic prog_stb_q;
   always_ff @(posedge CLOCK or negedge ARST_N) begin
      if (!ARST_N) begin
         PROG_INSTR <= bstp_pkg::PROG_REG_RESET[9:0];
         PROG_DATA <= bstp_pkg::PROG_REG_RESET;
         prog_active_q <= 1'b0;
         prog_stb_q <= 1'b0;
      end else begin
         PROG_INSTR <= ir_q;
         if (ir.update || ir.reset) prog_active_q <= 1'b0;
         if (dr.update && is_prog) prog_active_q <= 1'b1;
         prog_stb_q <= dr.update && is_prog_data;
         if (dr.update && is_prog_data) PROG_DATA <= prog_q;
      end
   end
   assign PROG_ACTIVE = prog_active_q;
   assign PROG_DATA_STB = prog_stb_q;
endmodule : bstp_boundary_scan_circuitry
`default_nettype wire

// File: testbench/bstp_port_asserts.sv
`timescale 1ns/100ps
`default_nettype none
module bstp_port_asserts (
   input wire logic CLOCK,
   input wire logic ARST_N,
   input wire logic PORT_ENABLE,
   input wire logic TCK_IN,
   input wire logic TDO_OUT,
   input wire logic TDO_OE,
   input wire logic [3:0] USER_PIN_IN,
   input wire logic [3:0] PORTPIN_OE,
   input wire logic PROG_ACTIVE,
   input wire logic [9:0] PROG_INSTR,
   input wire logic [15:0] PROG_DATA,
   input wire logic PROG_DATA_STB
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!ARST_N);
   // tdo moves a few clocks after a tck fall, so a long high phase must leave it still
   chk_tdo_held_high:
      assert property ((TCK_IN && PORT_ENABLE) [*2] |-> $stable(TDO_OUT))
      else $error("tdo moved while tck high");
   chk_oe_held_high:
      assert property ((TCK_IN && PORT_ENABLE) [*2] |-> $stable(TDO_OE))
      else $error("tdo enable moved while tck high");
   chk_disabled_no_oe:
      assert property ((!PORT_ENABLE) [*5] |-> !TDO_OE)
      else $error("tdo driven while port disabled");
   chk_enabled_pins_quiet:
      assert property (PORT_ENABLE [*5] |-> USER_PIN_IN == 4'h0 && PORTPIN_OE == 4'h0)
      else $error("user pin path active while port enabled");
   chk_tdo_pin_reads_zero:
      assert property (USER_PIN_IN[0] == 1'b0)
      else $error("output-only pin read back non-zero");
   chk_stb_one_cycle:
      assert property (PROG_DATA_STB |=> !PROG_DATA_STB)
      else $error("programming strobe longer than one cycle");
   chk_stb_after_load:
      assert property ($changed(PROG_DATA) |-> PROG_DATA_STB)
      else $error("programming word loaded without strobe");
   chk_active_prog_instr:
      assert property (PROG_ACTIVE |-> PROG_INSTR[9:2] == 8'h28)
      else $error("programming active under another instruction");
   chk_active_after_select:
      assert property ($rose(PROG_ACTIVE) |-> $past(PROG_INSTR[9:2]) == 8'h28)
      else $error("programming active before instruction selected");
endmodule : bstp_port_asserts
bind bstp_boundary_scan_circuitry bstp_port_asserts chk_u (.CLOCK, .ARST_N, .PORT_ENABLE, .TCK_IN, .TDO_OUT,
   .TDO_OE, .USER_PIN_IN, .PORTPIN_OE, .PROG_ACTIVE, .PROG_INSTR, .PROG_DATA, .PROG_DATA_STB);
`default_nettype wire

// File: testbench/bstp_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module bstp_host_model (
   input wire logic clk,
   input wire logic tdo,
   output logic tck,
   output logic tms,
   output logic tdi
);
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end
   // four system clocks per half period gives the 80 ns test clock; tck rests low between frames
   task automatic pulse(input logic m, input logic d, output logic o);
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk);
      tck = 1'b1;
      repeat (4) @(negedge clk);
      // sampled late in the high phase: tdo still holds the bit set at the previous fall
      o = tdo;
      tck = 1'b0;
   endtask : pulse
   task automatic reset_tap;
      logic o;
      repeat (5) pulse(1'b1, 1'b0, o);
      pulse(1'b0, 1'b0, o);
   endtask : reset_tap
   task automatic scan(input logic ir, input int n, input logic [647:0] din, output logic [647:0] dout);
      logic o;
      dout = '0;
      pulse(1'b1, 1'b0, o);
      if (ir) pulse(1'b1, 1'b0, o);
      pulse(1'b0, 1'b0, o);
      pulse(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++) begin
         pulse(i == n - 1, din[i], o);
         dout[i] = o;
      end
      // tdi keeps toggling after the frame so a stale level is never mistaken for data
      pulse(1'b1, ~din[n-1], o);
      pulse(1'b0, din[n-1], o);
   endtask : scan
   task automatic pins(input logic c, input logic m, input logic d);
      tck = c;
      tms = m;
      tdi = d;
   endtask : pins
endmodule : bstp_host_model
`default_nettype wire

// File: testbench/test_bstp_boundary_scan_circuitry.sv
`timescale 1ns/100ps
`default_nettype none
module test_bstp_boundary_scan_circuitry;
   localparam int W = 648;
   localparam int BSR = bstp_pkg::BSR_MIN;
   localparam int NP = BSR / 3;
   // identity values are arbitrary
   localparam logic [3:0] VER = 4'h3;
   localparam logic [15:0] PART = 16'h5A5A;
   localparam logic [10:0] MAKER = 11'h155;
   localparam logic [15:0] SIG = 16'h3C96;
   logic clock, arst_n, port_enable, tck, tms, tdi, tdo_out, tdo_oe, prog_active, prog_data_stb;
   logic [3:0] user_pin_in, user_pin_out, user_pin_oe, portpin_out, portpin_oe;
   logic [NP-1:0] core_out, core_oe, pad_in, pad_out, pad_oe, core_in;
   logic [9:0] prog_instr;
   logic [15:0] prog_data;
   logic [W-1:0] dout;
   int fails = 0;
   int samples_checked = 0;
   int cycles = 0;
   bstp_boundary_scan_circuitry #(.BSR_LEN(BSR), .ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKER),
      .USER_SIG(SIG)) dut_u (.CLOCK(clock), .ARST_N(arst_n), .PORT_ENABLE(port_enable), .TCK_IN(tck),
      .TMS_IN(tms), .TDI_IN(tdi), .TDO_OUT(tdo_out), .TDO_OE(tdo_oe), .USER_PIN_IN(user_pin_in),
      .USER_PIN_OUT(user_pin_out), .USER_PIN_OE(user_pin_oe), .PORTPIN_OUT(portpin_out),
      .PORTPIN_OE(portpin_oe), .CORE_OUT(core_out), .CORE_OE(core_oe), .PAD_IN(pad_in), .PAD_OUT(pad_out),
      .PAD_OE(pad_oe), .CORE_IN(core_in), .PROG_ACTIVE(prog_active), .PROG_INSTR(prog_instr),
      .PROG_DATA(prog_data), .PROG_DATA_STB(prog_data_stb));
   bstp_host_model host_u (.clk(clock), .tdo(tdo_out), .tck(tck), .tms(tms), .tdi(tdi));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : close_out
   // whole run is near 12000 cycles
   always @(posedge clock) begin
      cycles++;
      if (cycles == 60000) begin
         fails++;
         close_out;
      end
   end
   task automatic check(input string what, input logic [W-1:0] seen, input logic [W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic ir(input logic [9:0] op);
      host_u.scan(1'b1, 10, W'(op), dout);
      check("ir capture", dout, W'(10'h001));
   endtask : ir
   task automatic dr(input int n, input logic [W-1:0] d);
      host_u.scan(1'b0, n, d, dout);
   endtask : dr
   task automatic t_ident;
      dr(40, W'(8'hC5));
      check("id after reset", dout, W'({8'hC5, VER, PART, MAKER, 1'b1}));
      ir(bstp_pkg::OP_USERSIG);
      dr(24, W'(8'h5A));
      check("signature", dout, W'({8'h5A, SIG}));
      ir(bstp_pkg::OP_IDCODE);
      dr(32, '0);
      check("id selected", dout, W'({VER, PART, MAKER, 1'b1}));
   endtask : t_ident
   task automatic t_bypass;
      for (int k = 0; k < 2; k++) begin
         ir(k == 0 ? bstp_pkg::OP_BYPASS : 10'h123);
         dr(9, W'(9'h0B5));
         check("bypass path", dout, W'(9'h16A));
         check("core runs", W'(pad_out), W'(core_out));
      end
   endtask : t_bypass
   task automatic t_boundary;
      logic [W-1:0] cap;
      logic [W-1:0] pat;
      logic [NP-1:0] eo;
      logic [NP-1:0] ee;
      logic [NP-1:0] ei;
      cap = '0;
      pat = {81{8'h69}};
      for (int i = 0; i < NP; i++) begin
         cap[3*i] = pad_in[i];
         cap[3*i+1] = core_out[i];
         cap[3*i+2] = core_oe[i];
         eo[i] = pat[3*i+1];
         ee[i] = pat[3*i+2];
         ei[i] = pat[3*i];
      end
      ir(bstp_pkg::OP_SAMPLE);
      dr(BSR, pat);
      check("sample capture", dout, cap);
      check("sample pads", W'(pad_out), W'(core_out));
      check("sample core in", W'(core_in), W'(pad_in));
      ir(bstp_pkg::OP_EXTEST);
      check("extest out", W'(pad_out), W'(eo));
      check("extest oe", W'(pad_oe), W'(ee));
      check("extest core in", W'(core_in), W'(ei));
      pad_in = ~pad_in;
      dr(BSR, pat);
      for (int i = 0; i < NP; i++) eo[i] = dout[3*i];
      check("extest capture", W'(eo), W'(pad_in));
      ir(bstp_pkg::OP_BYPASS);
      check("pads released", W'(pad_out), W'(core_out));
      check("core in released", W'(core_in), W'(pad_in));
   endtask : t_boundary
   task automatic t_prog;
      logic [9:0] ops [4];
      logic [15:0] word;
      logic [15:0] held;
      ops = '{bstp_pkg::OP_PROG_ENTER, bstp_pkg::OP_PROG_ADDR, bstp_pkg::OP_PROG_DATA, bstp_pkg::OP_PROG_EXIT};
      held = bstp_pkg::PROG_REG_RESET;
      for (int k = 0; k < 4; k++) begin
         ir(ops[k]);
         word = 16'(16'h1111 * (k + 1));
         dr(16, W'(word));
         check("prog capture", dout, (k == 1 || k == 2) ? W'(held) : W'({word[14:0], 1'b0}));
         if (k == 1 || k == 2) held = word;
         check("prog data", W'(prog_data), W'(held));
         check("prog instr", W'(prog_instr), W'(ops[k]));
         check("prog active", W'(prog_active), W'(1'b1));
      end
      ir(bstp_pkg::OP_BYPASS);
      check("prog cleared", W'(prog_active), W'(1'b0));
   endtask : t_prog
   task automatic t_disabled;
      port_enable = 1'b0;
      host_u.pins(1'b1, 1'b0, 1'b1);
      user_pin_out = 4'h9;
      user_pin_oe = 4'hC;
      repeat (6) @(negedge clock);
      check("pins in", W'(user_pin_in), W'(4'hA));
      check("pins out", W'(portpin_out), W'(4'h9));
      check("pins oe", W'(portpin_oe), W'(4'hC));
      check("tdo oe", W'(tdo_oe), W'(1'b0));
      host_u.pins(1'b0, 1'b1, 1'b0);
      port_enable = 1'b1;
      repeat (6) @(negedge clock);
      host_u.reset_tap;
      dr(32, '0);
      check("id after enable", dout, W'({VER, PART, MAKER, 1'b1}));
   endtask : t_disabled
   initial begin
      arst_n = 1'b0;
      port_enable = 1'b1;
      pad_in = {NP/8{8'hA3}};
      core_out = {NP/8{8'h5C}};
      core_oe = {NP/8{8'hF0}};
      user_pin_out = 4'h0;
      user_pin_oe = 4'h0;
      repeat (3) @(negedge clock);
      arst_n = 1'b1;
      repeat (4) @(negedge clock);
      host_u.reset_tap;
      t_ident;
      t_bypass;
      t_boundary;
      t_prog;
      t_disabled;
      close_out;
   end
endmodule : test_bstp_boundary_scan_circuitry
`default_nettype wire
